// ### addr_classify.sv
// Combinational classifier: address bits to target, offset and window hit
`timescale 1ns/10ps
module addr_classify (
	// Address in, decision out
	decode_if.dec dif
);
	logic [addr_map_pkg::WIN_TAG_W-1:0] tag;

	always_comb begin
		tag = dif.addr[addr_map_pkg::WIN_TAG_LO +: addr_map_pkg::WIN_TAG_W];
		dif.offset = dif.addr[addr_map_pkg::PROG_OFS_W-1:0];
		if (!dif.addr[addr_map_pkg::SPACE_BIT]) begin // [RL5] [RL2]
			dif.target    = addr_map_pkg::TGT_PROG;
			dif.in_window = 1'b1;
		end else if (!dif.addr[addr_map_pkg::PERIPH_BIT]) begin // [RL6] [RL3]
			dif.target    = addr_map_pkg::TGT_REG;
			dif.in_window = (tag == addr_map_pkg::REG_WIN_TAG);
		end else begin // [RL6] [RL4]
			dif.target    = addr_map_pkg::TGT_SRAM;
			dif.in_window = (tag == addr_map_pkg::SRAM_WIN_TAG);
		end
	end
endmodule

// ### addr_map_pkg.sv
// Address map constants and target encoding for the core address decoder
package addr_map_pkg;
	localparam int ADDR_W       = 24;
	localparam int SPACE_BIT    = 23;
	localparam int PERIPH_BIT   = 18;
	localparam int PROG_OFS_W   = 23;
	localparam int WIN_OFS_W    = 16;
	localparam int WIN_TAG_LO   = 16;
	localparam int WIN_TAG_W    = 7;
	localparam int DATA_W       = 32;
	localparam int BE_W         = 4;
	localparam int TGT_W        = 3;

	localparam logic [ADDR_W-1:0] PROG_BASE = 24'h000000;
	localparam logic [ADDR_W-1:0] PROG_TOP  = 24'h7FFFFF;
	localparam logic [ADDR_W-1:0] REG_BASE  = 24'h800000;
	localparam logic [ADDR_W-1:0] REG_TOP   = 24'h80FFFF;
	localparam logic [ADDR_W-1:0] SRAM_BASE = 24'h840000;
	localparam logic [ADDR_W-1:0] SRAM_TOP  = 24'h84FFFF;

	// Bits 22:16 that mark the documented windows inside peripheral space
	localparam logic [WIN_TAG_W-1:0] REG_WIN_TAG  = 7'h00;
	localparam logic [WIN_TAG_W-1:0] SRAM_WIN_TAG = 7'h04;

	localparam logic [TGT_W-1:0] TGT_IDLE = 3'h0;

	typedef enum logic [TGT_W-1:0] {
		TGT_PROG = 3'b001,
		TGT_REG  = 3'b010,
		TGT_SRAM = 3'b100
	} target_t;
endpackage

// ### addr_space_decoder.sv
// Core address decoder: steers 24-bit accesses to program, register or SRAM
//
// Summary of operation
// RL1: The core presents a 24-bit byte address covering a 16 MB space.
// RL2: Addresses 0x000000 to 0x7FFFFF, the lower 8 MB, go to program memory.
// RL3: The 64 KB window 0x800000 to 0x80FFFF goes to the register target.
// RL4: The 64 KB window 0x840000 to 0x84FFFF goes to the on-chip SRAM.
// RL5: Address bit 23 low selects program space, high selects peripherals.
// RL6: With bit 23 high, bit 18 low selects registers, high selects SRAM.
// RL7: Lower address bits pass unchanged as offset, one select per access.
`timescale 1ns/10ps
module addr_space_decoder #(
	parameter int DW = addr_map_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic                                clk_sys,
	input  wire logic                                rst,
	// Core request
	input  wire logic                                core_req,
	input  wire logic [addr_map_pkg::ADDR_W-1:0]     core_addr,
	input  wire logic                                core_write,
	input  wire logic [addr_map_pkg::BE_W-1:0]       core_be,
	input  wire logic [DW-1:0]                       core_wdata,
	// Core response
	output logic                                     core_rvalid,
	output logic [DW-1:0]                            core_rdata,
	output logic                                     core_map_miss,
	// Program memory target
	output logic                                     prog_sel,
	output logic [addr_map_pkg::PROG_OFS_W-1:0]      prog_offset,
	input  wire logic                                prog_rvalid,
	input  wire logic [DW-1:0]                       prog_rdata,
	// Register target
	output logic                                     reg_sel,
	output logic [addr_map_pkg::WIN_OFS_W-1:0]       reg_offset,
	input  wire logic                                reg_rvalid,
	input  wire logic [DW-1:0]                       reg_rdata,
	// SRAM target
	output logic                                     sram_sel,
	output logic [addr_map_pkg::WIN_OFS_W-1:0]       sram_offset,
	input  wire logic                                sram_rvalid,
	input  wire logic [DW-1:0]                       sram_rdata,
	// Shared write path to all targets
	output logic                                     tgt_write,
	output logic [addr_map_pkg::BE_W-1:0]            tgt_be,
	output logic [DW-1:0]                            tgt_wdata
);
	decode_if dif ();

	logic [addr_map_pkg::TGT_W-1:0]      sel;
	logic [addr_map_pkg::TGT_W-1:0]      next_sel;
	logic [addr_map_pkg::PROG_OFS_W-1:0] offset;
	logic [addr_map_pkg::PROG_OFS_W-1:0] next_offset;
	logic                                miss;
	logic                                next_miss;
	logic                                wr;
	logic                                next_wr;
	logic [addr_map_pkg::BE_W-1:0]       be;
	logic [addr_map_pkg::BE_W-1:0]       next_be;
	logic [DW-1:0]                       wdata;
	logic [DW-1:0]                       next_wdata;
	logic [addr_map_pkg::TGT_W-1:0]      owner;
	logic [addr_map_pkg::TGT_W-1:0]      next_owner;
	logic                                rvalid;
	logic                                next_rvalid;
	logic [DW-1:0]                       rdata;
	logic [DW-1:0]                       next_rdata;

	assign dif.addr = core_addr;

	addr_classify u_classify (
		.dif (dif)
	);

	// Request path: decide and register the select, offset and write data
	always_comb begin
		next_sel    = addr_map_pkg::TGT_IDLE;
		next_offset = offset;
		next_miss   = 1'b0;
		next_wr     = wr;
		next_be     = be;
		next_wdata  = wdata;
		if (core_req) begin
			next_sel    = dif.target; // [RL5] [RL6] [RL7]
			next_offset = dif.offset; // [RL1] [RL7]
			next_miss   = !dif.in_window;
			next_wr     = core_write;
			next_be     = core_be;
			next_wdata  = core_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel    <= addr_map_pkg::TGT_IDLE;
			offset <= '0;
			miss   <= 1'b0;
			wr     <= 1'b0;
			be     <= '0;
			wdata  <= '0;
		end else begin
			sel    <= next_sel;
			offset <= next_offset;
			miss   <= next_miss;
			wr     <= next_wr;
			be     <= next_be;
			wdata  <= next_wdata;
		end
	end

	// Peripheral windows alias across bits 22:19 and 17:16; miss flags it
	assign prog_sel      = sel[0]; // [RL2]
	assign reg_sel       = sel[1]; // [RL3]
	assign sram_sel      = sel[2]; // [RL4]
	assign prog_offset   = offset;
	assign reg_offset    = offset[addr_map_pkg::WIN_OFS_W-1:0]; // [RL3]
	assign sram_offset   = offset[addr_map_pkg::WIN_OFS_W-1:0]; // [RL4]
	assign core_map_miss = miss;
	assign tgt_write     = wr;
	assign tgt_be        = be;
	assign tgt_wdata     = wdata;

	// Response path: only the target of the latest read may answer
	always_comb begin
		next_owner = owner;
		if (core_req && !core_write) begin
			next_owner = dif.target;
		end
		next_rvalid = 1'b0;
		next_rdata  = rdata;
		case (owner)
			addr_map_pkg::TGT_PROG: begin
				next_rvalid = prog_rvalid;
				if (prog_rvalid) next_rdata = prog_rdata;
			end
			addr_map_pkg::TGT_REG: begin
				next_rvalid = reg_rvalid;
				if (reg_rvalid) next_rdata = reg_rdata;
			end
			addr_map_pkg::TGT_SRAM: begin
				next_rvalid = sram_rvalid;
				if (sram_rvalid) next_rdata = sram_rdata;
			end
			default: begin
				next_rvalid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			owner  <= addr_map_pkg::TGT_IDLE;
			rvalid <= 1'b0;
			rdata  <= '0;
		end else begin
			owner  <= next_owner;
			rvalid <= next_rvalid;
			rdata  <= next_rdata;
		end
	end

	assign core_rvalid = rvalid;
	assign core_rdata  = rdata;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_one_select;
		sel != addr_map_pkg::TGT_IDLE |-> $onehot(sel);
	endproperty
	a_one_select: assert property (p_one_select) // [RL7]
		else $error("more than one target selected");

	property p_prog_route;
		core_req && !core_addr[addr_map_pkg::SPACE_BIT]
			|=> prog_sel && !reg_sel && !sram_sel;
	endproperty
	a_prog_route: assert property (p_prog_route) // [RL5]
		else $error("bit 23 low did not select program space");

	property p_reg_route;
		core_req && core_addr[addr_map_pkg::SPACE_BIT]
			&& !core_addr[addr_map_pkg::PERIPH_BIT]
			|=> reg_sel && !prog_sel && !sram_sel;
	endproperty
	a_reg_route: assert property (p_reg_route) // [RL6]
		else $error("register space not selected");

	property p_sram_route;
		core_req && core_addr[addr_map_pkg::SPACE_BIT]
			&& core_addr[addr_map_pkg::PERIPH_BIT]
			|=> sram_sel && !prog_sel && !reg_sel;
	endproperty
	a_sram_route: assert property (p_sram_route) // [RL6]
		else $error("SRAM space not selected");

	property p_prog_top;
		core_req && core_addr == addr_map_pkg::PROG_TOP
			|=> prog_sel && prog_offset == 23'h7FFFFF;
	endproperty
	a_prog_top: assert property (p_prog_top) // [RL1]
		else $error("top of program space misrouted");

	property p_reg_window;
		core_req && core_addr >= addr_map_pkg::REG_BASE
			&& core_addr <= addr_map_pkg::REG_TOP
			|=> reg_sel && !core_map_miss
			&& reg_offset == $past(core_addr[15:0]);
	endproperty
	a_reg_window: assert property (p_reg_window) // [RL3]
		else $error("register window misrouted");

	property p_sram_window;
		core_req && core_addr >= addr_map_pkg::SRAM_BASE
			&& core_addr <= addr_map_pkg::SRAM_TOP
			|=> sram_sel && !core_map_miss
			&& sram_offset == $past(core_addr[15:0]);
	endproperty
	a_sram_window: assert property (p_sram_window) // [RL4]
		else $error("SRAM window misrouted");

	property p_prog_offset;
		core_req && !core_addr[addr_map_pkg::SPACE_BIT]
			|=> prog_offset == $past(core_addr[22:0]) && !core_map_miss;
	endproperty
	a_prog_offset: assert property (p_prog_offset) // [RL2]
		else $error("program offset altered");

	property p_idle;
		!core_req |=> sel == addr_map_pkg::TGT_IDLE;
	endproperty
	a_idle: assert property (p_idle) // [RL7]
		else $error("select without a request");

	c_prog_read: cover property (core_req && !core_write
		&& !core_addr[23] ##1 prog_sel ##[1:8] core_rvalid);
	c_reg_write: cover property (core_req && core_write
		&& core_addr[23] && !core_addr[18] ##1 reg_sel);
	c_sram_back: cover property (core_req && core_addr[23]
		&& core_addr[18] ##1 sram_sel && core_req);
	c_miss: cover property (core_map_miss);
endmodule

// ### decode_if.sv
// Carrier between the decoder top and its address classifier
`timescale 1ns/10ps
interface decode_if;
	logic [addr_map_pkg::ADDR_W-1:0]     addr;
	addr_map_pkg::target_t               target;
	logic [addr_map_pkg::PROG_OFS_W-1:0] offset;
	logic                                in_window;

	modport req (output addr, input target, input offset, input in_window);
	modport dec (input addr, output target, output offset, output in_window);
endinterface

// ### target_model.sv
// Behavioural target memory that answers reads after a set latency
`timescale 1ns/10ps
module target_model #(
	parameter int         OW  = 16,
	parameter int         LAT = 1,
	// Default tag matches the register target, so that instance needs none
	parameter logic [7:0] TAG = 8'h22
) (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst,
	// Select side
	input  wire logic          sel,
	input  wire logic          write,
	input  wire logic [OW-1:0] offset,
	// Response side
	output logic               rvalid,
	output logic [31:0]        rdata
);
	int          cnt;
	logic [31:0] held;

	always @(posedge clk_sys) begin
		if (rst) begin
			cnt    <= 0;
			rvalid <= 1'b0;
			rdata  <= 32'h0;
		end else begin
			if (sel && !write) begin
				cnt  <= LAT;
				held <= {TAG, 24'(offset)};
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
			end
			rvalid <= (cnt == 1);
			// Data is not held outside the pulse
			rdata  <= (cnt == 1) ? held : ~rdata;
		end
	end
endmodule

// ### tb_mcu_address_space_decoder.sv
// Self-checking bench for the core address decoder
`timescale 1ns/10ps
module tb_mcu_address_space_decoder;
	typedef struct packed {
		logic [23:0] a;
		logic        w;
		logic [2:0]  t;
		logic        m;
	} row_t;

	logic        clk_sys = 0, rst = 1, core_req = 0, core_write = 0;
	logic [23:0] core_addr = '0;
	logic [3:0]  core_be = '0, tgt_be;
	logic [31:0] core_wdata = '0, core_rdata, tgt_wdata;
	logic [31:0] prog_rdata, reg_rdata, sram_rdata;
	logic        core_rvalid, core_map_miss, tgt_write;
	logic        prog_sel, reg_sel, sram_sel;
	logic        prog_rvalid, reg_rvalid, sram_rvalid;
	logic [22:0] prog_offset;
	logic [15:0] reg_offset, sram_offset;
	int          bad_count = 0, n_tests = 0;
	row_t        rows [10] = '{
		{24'h000000, 1'b0, 3'h1, 1'b0}, {24'h7FFFFF, 1'b1, 3'h1, 1'b0},
		{24'h400123, 1'b0, 3'h1, 1'b0}, {24'h800000, 1'b1, 3'h2, 1'b0},
		{24'h80FFFF, 1'b0, 3'h2, 1'b0}, {24'h840000, 1'b0, 3'h4, 1'b0},
		{24'h84FFFF, 1'b1, 3'h4, 1'b0}, {24'h810000, 1'b0, 3'h2, 1'b1},
		{24'h8C0000, 1'b1, 3'h4, 1'b1}, {24'hFFFFFF, 1'b0, 3'h4, 1'b1}};

	always #50 clk_sys = ~clk_sys;

	addr_space_decoder i_dut (.clk_sys(clk_sys), .rst(rst),
		.core_req(core_req), .core_addr(core_addr), .core_write(core_write),
		.core_be(core_be), .core_wdata(core_wdata),
		.core_rvalid(core_rvalid), .core_rdata(core_rdata),
		.core_map_miss(core_map_miss), .prog_sel(prog_sel),
		.prog_offset(prog_offset), .prog_rvalid(prog_rvalid),
		.prog_rdata(prog_rdata), .reg_sel(reg_sel), .reg_offset(reg_offset),
		.reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .sram_sel(sram_sel),
		.sram_offset(sram_offset), .sram_rvalid(sram_rvalid),
		.sram_rdata(sram_rdata), .tgt_write(tgt_write), .tgt_be(tgt_be),
		.tgt_wdata(tgt_wdata));
	target_model #(.OW(23), .LAT(2), .TAG(8'h11)) i_prog (.clk_sys(clk_sys),
		.rst(rst), .sel(prog_sel), .write(tgt_write), .offset(prog_offset),
		.rvalid(prog_rvalid), .rdata(prog_rdata));
	target_model i_reg (.clk_sys(clk_sys),
		.rst(rst), .sel(reg_sel), .write(tgt_write), .offset(reg_offset),
		.rvalid(reg_rvalid), .rdata(reg_rdata));
	// Slow target so the read path waits several cycles
	target_model #(.LAT(4), .TAG(8'h33)) i_sram (.clk_sys(clk_sys),
		.rst(rst), .sel(sram_sel), .write(tgt_write), .offset(sram_offset),
		.rvalid(sram_rvalid), .rdata(sram_rdata));

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task print_verdict;
		$display("Comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task drive(input logic [23:0] a, input logic w);
		core_req   <= 1'b1;
		core_addr  <= a;
		core_write <= w;
		core_be    <= w ? 4'hC : 4'h3;
		core_wdata <= {8'hA5, a};
	endtask

	task check_take(input logic [23:0] a, input logic w, input logic [2:0] t,
		input logic m);
		chk({sram_sel, reg_sel, prog_sel}, t);
		chk(core_map_miss, m);
		chk(t[0] ? prog_offset : t[1] ? reg_offset : sram_offset,
			t[0] ? a[22:0] : a[15:0]);
		chk(tgt_wdata, {8'hA5, a});
		chk({tgt_write, tgt_be}, {w, w ? 4'hC : 4'h3});
	endtask

	task wait_read(input logic [23:0] a, input logic [2:0] t);
		int         k;
		logic [7:0] tag;
		tag = t[0] ? 8'h11 : t[1] ? 8'h22 : 8'h33;
		for (k = 0; k < 12 && core_rvalid !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		chk(core_rvalid, 1);
		chk(core_rdata, {tag, t[0] ? {1'b0, a[22:0]} : {8'h0, a[15:0]}});
	endtask

	task access(input logic [23:0] a, input logic w, input logic [2:0] t,
		input logic m);
		@(posedge clk_sys);
		drive(a, w);
		@(posedge clk_sys);
		core_req <= 1'b0;
		#1 check_take(a, w, t, m);
		if (!w)
			wait_read(a, t);
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		#1 chk({prog_sel, reg_sel, sram_sel, core_rvalid, core_map_miss}, 0);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 10; i++) begin
				access(rows[i].a, rows[i].w ^ j[0], rows[i].t, rows[i].m);
				$display("Row %0d pass %0d done", i, j);
			end
		end
		@(posedge clk_sys);
		drive(24'h84ABCD, 1'b1);
		@(posedge clk_sys);
		drive(24'h001234, 1'b0);
		// First request was taken at this edge; its select stands one cycle
		#1 check_take(24'h84ABCD, 1'b1, 3'h4, 1'b0);
		@(posedge clk_sys);
		core_req <= 1'b0;
		#1 check_take(24'h001234, 1'b0, 3'h1, 1'b0);
		wait_read(24'h001234, 3'h1);
		@(posedge clk_sys);
		#1 chk({prog_sel, reg_sel, sram_sel}, 0);
		$display("Back to back done");
		@(posedge clk_sys);
		drive(24'h80FF00, 1'b1);
		rst <= 1'b1;
		@(posedge clk_sys);
		core_req <= 1'b0;
		@(posedge clk_sys);
		rst <= 1'b0;
		#1 chk({prog_sel, reg_sel, sram_sel, core_rvalid, tgt_write}, 0);
		chk(tgt_wdata | core_rdata | reg_offset, 0);
		access(24'h840004, 1'b0, 3'h4, 1'b0);
		$display("Reset test done");
		print_verdict;
	end

	initial begin
		#(100 * 3000);
		$display("Watchdog expired");
		bad_count++;
		print_verdict;
	end
endmodule
